/* core/gpcfg_pkg.sv */
// Constants, types and helpers for the per-pin configuration bank
// Operation
// - Direction bit per pin: 0 input, 1 output; rows, columns 0-7, columns 8-9.
// - Level bit picks interrupt polarity of an input: 0 low, 1 high.
// - Filter bypass bit: 0 keeps debounce, 1 bypasses it for that pin.
// - Pull-up off bit: 0 keeps input pull-up, 1 removes it.
// - Pull control acts on inputs only; outputs are driven unaffected.
// - Answer at write byte 0x68/read 0x69, or 0x60/0x61 in alternate variant.
package gpcfg_pkg;

	localparam int NUM_PINS = 18;
	localparam int NUM_REGS = 12;
	localparam int BYTES_PER_FUNC = 3;
	localparam int BITS_PER_BYTE = 8;

	// Register offsets
	localparam logic [7:0] OFF_DIR_ROWS = 8'h23;
	localparam logic [7:0] OFF_DIR_COLS_LOW = 8'h24;
	localparam logic [7:0] OFF_DIR_COLS_HIGH = 8'h25;
	localparam logic [7:0] OFF_IRQ_LEVEL_ROWS = 8'h26;
	localparam logic [7:0] OFF_IRQ_LEVEL_COLS_LOW = 8'h27;
	localparam logic [7:0] OFF_IRQ_LEVEL_COLS_HIGH = 8'h28;
	localparam logic [7:0] OFF_FILTER_BYPASS_ROWS = 8'h29;
	localparam logic [7:0] OFF_FILTER_BYPASS_COLS_LOW = 8'h2a;
	localparam logic [7:0] OFF_FILTER_BYPASS_COLS_HIGH = 8'h2b;
	localparam logic [7:0] OFF_PULLUP_OFF_ROWS = 8'h2c;
	localparam logic [7:0] OFF_PULLUP_OFF_COLS_LOW = 8'h2d;
	localparam logic [7:0] OFF_PULLUP_OFF_COLS_HIGH = 8'h2e;

	// Function index within the bank, three bytes each
	localparam logic [1:0] FUNC_DIR = 2'h0;
	localparam logic [1:0] FUNC_IRQ_LEVEL = 2'h1;
	localparam logic [1:0] FUNC_FILTER_BYPASS = 2'h2;
	localparam logic [1:0] FUNC_PULLUP_OFF = 2'h3;

	// Field layout of the third byte of each function, register reset value and unmapped read value
	localparam logic [7:0] HIGH_BYTE_MASK = 8'h03;
	localparam int HIGH_BYTE_BITS = 2;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Bus address bytes (write form; read form has bit 0 set)
	localparam logic [7:0] ADDR_WR_STD = 8'h68;
	localparam logic [7:0] ADDR_WR_ALT = 8'h60;

	typedef logic [NUM_REGS-1:0][7:0] gpcfg_bank_t;

	typedef struct packed {
		logic [NUM_PINS-1:0] dir;
		logic [NUM_PINS-1:0] irq_level;
		logic [NUM_PINS-1:0] filter_bypass;
		logic [NUM_PINS-1:0] pullup_en;
	} gpcfg_pins_s;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_PTR,
		ST_ACK_PTR,
		ST_WRITE,
		ST_ACK_WRITE,
		ST_READ,
		ST_ACK_READ
	} gpcfg_state_e;

	function automatic logic in_bank(input logic [7:0] off);
		return (off >= OFF_DIR_ROWS) && (off <= OFF_PULLUP_OFF_COLS_HIGH);
	endfunction

	function automatic logic [3:0] bank_index(input logic [7:0] off);
		logic [7:0] diff;
		diff = off - OFF_DIR_ROWS;
		return diff[3:0];
	endfunction

	function automatic logic is_high_byte(input logic [3:0] idx);
		return (idx == 4'h2) || (idx == 4'h5) || (idx == 4'h8) || (idx == 4'hb);
	endfunction

	// Gathers rows, columns 0-7 and columns 8-9 of one function into pin order
	function automatic logic [NUM_PINS-1:0] pin_field(input gpcfg_bank_t bank,
		input logic [1:0] func);
		logic [3:0] base;
		base = 4'(func * BYTES_PER_FUNC);
		return {bank[base + 4'h2][HIGH_BYTE_BITS-1:0], bank[base + 4'h1], bank[base]};
	endfunction

endpackage

/* core/gpcfg_regmem.sv */
// Configuration byte store with registered read port
`timescale 1ns/1ps
module gpcfg_regmem import gpcfg_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Write port
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic rd_hit,
	input wire logic [3:0] rd_idx,
	output logic [7:0] rd_data,
	// Whole bank for the pin logic
	output gpcfg_bank_t bank
);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bank <= {NUM_REGS{REG_RESET}};
		end else if (wr_en) begin
			// Spare bits of the third bytes never hold a one
			bank[wr_idx] <= is_high_byte(wr_idx) ? (wr_data & HIGH_BYTE_MASK) : wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data <= UNMAPPED_READ;
		end else begin
			rd_data <= rd_hit ? bank[rd_idx] : UNMAPPED_READ;
		end
	end

endmodule

/* core/gpcfg_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module gpcfg_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stage1 <= '1;
			sync_out <= '1;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

/* core/gpcfg_top.sv */
// Per-pin configuration bank behind a two-wire serial slave
`timescale 1ns/1ps
module gpcfg_top import gpcfg_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Serial bus pins, data is open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Address variant strap, high selects the alternate address
	input wire logic addr_alt_strap,
	// Keypad selection per pin, high means keypad, same clock
	input wire logic [NUM_PINS-1:0] keypad_sel,
	// Effective per-pin settings
	output gpcfg_pins_s pin_cfg
);

	logic scl_s;
	logic sda_s;
	logic strap_s;
	logic scl_q;
	logic sda_q;
	logic strap_taken;
	logic [1:0] strap_age;
	logic addr_alt;
	gpcfg_state_e state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic [7:0] ptr;
	logic rw;
	logic [7:0] rd_data;
	gpcfg_bank_t bank;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_done;
	logic [6:0] own_addr;
	logic wr_en;

	gpcfg_sync #(
		.WIDTH(3)
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in({scl_in, sda_in, addr_alt_strap}),
		.sync_out({scl_s, sda_s, strap_s})
	);

	gpcfg_regmem u_regmem (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_en(wr_en),
		.wr_idx(bank_index(ptr)),
		.wr_data(shreg),
		.rd_hit(in_bank(ptr)),
		.rd_idx(bank_index(ptr)),
		.rd_data(rd_data),
		.bank(bank)
	);

	// Edge and condition detection on synchronised pins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;
	assign byte_done = (bit_cnt == 4'(BITS_PER_BYTE));

	// Strap is caught once after reset release, so a toggling pin cannot move the address
	// Synchroniser still shows its reset ones for two edges, so the catch waits them out
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			strap_age <= 2'h0;
			strap_taken <= 1'b0;
			addr_alt <= 1'b0;
		end else if (!strap_taken) begin
			strap_age <= {strap_age[0], 1'b1};
			if (strap_age[1]) begin
				strap_taken <= 1'b1;
				addr_alt <= strap_s;
			end
		end
	end

	assign own_addr = addr_alt ? ADDR_WR_ALT[7:1] : ADDR_WR_STD[7:1];

	// Data byte is stored at the falling edge after its eighth bit
	// Pointers outside the bank would alias onto it through the short index
	assign wr_en = (state == ST_WRITE) && scl_fall && byte_done && in_bank(ptr)
		&& !start_cond && !stop_cond;

	// Receive shift register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			shreg <= 8'h00;
		end else if (scl_rise) begin
			shreg <= {shreg[6:0], sda_s};
		end
	end

	// Bus transaction sequencer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			ptr <= 8'h00;
			rw <= 1'b0;
			tx <= 8'h00;
			sda_oe_n <= 1'b1;
		end else if (start_cond) begin
			// Repeated start keeps the pointer for a following read
			state <= ST_ADDR;
			bit_cnt <= 4'h0;
			sda_oe_n <= 1'b1;
		end else if (stop_cond) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			sda_oe_n <= 1'b1;
		end else begin
			case (state)
				ST_IDLE: begin
					sda_oe_n <= 1'b1;
				end
				ST_ADDR, ST_PTR, ST_WRITE: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						bit_cnt <= 4'h0;
						if (state == ST_ADDR) begin
							if (shreg[7:1] == own_addr) begin
								rw <= shreg[0];
								sda_oe_n <= 1'b0;
								state <= ST_ACK_ADDR;
							end else begin
								state <= ST_IDLE;
							end
						end else if (state == ST_PTR) begin
							ptr <= shreg;
							sda_oe_n <= 1'b0;
							state <= ST_ACK_PTR;
						end else begin
							// Bytes outside the bank are acknowledged and dropped
							sda_oe_n <= 1'b0;
							state <= ST_ACK_WRITE;
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						if (rw) begin
							tx <= rd_data;
							sda_oe_n <= rd_data[7];
							ptr <= ptr + 8'h01;
							state <= ST_READ;
						end else begin
							sda_oe_n <= 1'b1;
							state <= ST_PTR;
						end
					end
				end
				ST_ACK_PTR: begin
					if (scl_fall) begin
						sda_oe_n <= 1'b1;
						state <= ST_WRITE;
					end
				end
				ST_ACK_WRITE: begin
					if (scl_fall) begin
						sda_oe_n <= 1'b1;
						ptr <= ptr + 8'h01;
						state <= ST_WRITE;
					end
				end
				ST_READ: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (byte_done) begin
							bit_cnt <= 4'h0;
							sda_oe_n <= 1'b1;
							state <= ST_ACK_READ;
						end else begin
							tx <= {tx[6:0], 1'b0};
							sda_oe_n <= tx[6];
						end
					end
				end
				ST_ACK_READ: begin
					if (scl_rise && sda_s) begin
						// Master refused: stay off the bus until the next start
						state <= ST_IDLE;
					end else if (scl_fall) begin
						tx <= rd_data;
						sda_oe_n <= rd_data[7];
						ptr <= ptr + 8'h01;
						state <= ST_READ;
					end
				end
				default: begin
					state <= ST_IDLE;
					sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	// Open-drain data only ever pulls low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// Effective pin settings; keypad pins ignore the bank
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_cfg.dir <= '0;
			pin_cfg.irq_level <= '0;
			pin_cfg.filter_bypass <= '0;
			pin_cfg.pullup_en <= '1;
		end else begin
			pin_cfg.dir <= pin_field(bank, FUNC_DIR) & ~keypad_sel;
			pin_cfg.irq_level <= pin_field(bank, FUNC_IRQ_LEVEL) & ~keypad_sel;
			pin_cfg.filter_bypass <= pin_field(bank, FUNC_FILTER_BYPASS) & ~keypad_sel;
			// Outputs never carry the pull-up, so their drive is the same whatever the bit says
			pin_cfg.pullup_en <= ~(pin_field(bank, FUNC_DIR) & ~keypad_sel)
				& ~(pin_field(bank, FUNC_PULLUP_OFF) & ~keypad_sel);
		end
	end

endmodule

/* verif/gpcfg_host.sv */
// Bus master model of the host processor
`timescale 1ns/1ps
module gpcfg_host (
	// Clock and wired data line
	input wire logic sys_clk,
	input wire logic sda,
	// Bus clock and open-drain data, high means released
	output logic scl,
	output logic sda_h
);
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	task automatic ph();
		repeat (10) @(negedge sys_clk);
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_h = b;
		ph();
		scl = 1'b1;
		ph();
		r = sda;
		scl = 1'b0;
	endtask
	task automatic start();
		sda_h = 1'b1;
		ph();
		scl = 1'b1;
		ph();
		sda_h = 1'b0;
		ph();
		scl = 1'b0;
	endtask
	task automatic stop();
		sda_h = 1'b0;
		ph();
		scl = 1'b1;
		ph();
		sda_h = 1'b1;
		ph();
	endtask
	task automatic send(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ok = ok & ~r;
	endtask
	task automatic wr(input logic [7:0] a, p, v[13], input int n, output logic ok);
		ok = 1'b1;
		start();
		send(a, ok);
		send(p, ok);
		for (int i = 0; i < n; i++)
			send(v[i], ok);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, p, input int n, output logic [7:0] v[13],
		output logic ok);
		logic r;
		ok = 1'b1;
		start();
		send(a, ok);
		send(p, ok);
		start();
		send(a | 8'h01, ok);
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--)
				bitx(1'b1, v[i][j]);
			bitx(i == n - 1, r);
		end
		stop();
	endtask
endmodule

/* verif/gpcfg_monitor.sv */
// Port checker for the configuration bank
`timescale 1ns/1ps
module gpcfg_monitor import gpcfg_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Data pin driver
	input wire logic sda_out,
	input wire logic sda_oe_n,
	// Pin selection and settings
	input wire logic [NUM_PINS-1:0] keypad_sel,
	input gpcfg_pins_s pin_cfg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Settings lag the keypad selection by one cycle
	sequence s_kp_steady;
		$stable(keypad_sel) ##1 $stable(keypad_sel);
	endsequence
	property p_kp_dir;
		s_kp_steady |-> (pin_cfg.dir & keypad_sel) == 18'h0;
	endproperty
	a_kp_dir: assert property (p_kp_dir)
		else $error("direction set on keypad pin");
	property p_kp_level;
		s_kp_steady |-> (pin_cfg.irq_level & keypad_sel) == 18'h0;
	endproperty
	a_kp_level: assert property (p_kp_level)
		else $error("level set on keypad pin");
	property p_kp_bypass;
		s_kp_steady |-> (pin_cfg.filter_bypass & keypad_sel) == 18'h0;
	endproperty
	a_kp_bypass: assert property (p_kp_bypass)
		else $error("bypass set on keypad pin");
	property p_kp_pull;
		s_kp_steady |-> (pin_cfg.pullup_en & keypad_sel) == keypad_sel;
	endproperty
	a_kp_pull: assert property (p_kp_pull)
		else $error("pull-up lost on keypad pin");
	property p_out_pull;
		(pin_cfg.dir & pin_cfg.pullup_en) == 18'h0;
	endproperty
	a_out_pull: assert property (p_out_pull)
		else $error("pull-up on output pin");
	property p_rst_pull;
		disable iff (1'b0) rst |=> pin_cfg.pullup_en == 18'h3ffff && pin_cfg.dir == 18'h0;
	endproperty
	a_rst_pull: assert property (p_rst_pull)
		else $error("reset settings wrong");
	property p_sda_low;
		sda_out == 1'b0;
	endproperty
	a_sda_low: assert property (p_sda_low)
		else $error("data pin driven high");
	// A stored byte is always acknowledged in the same cycle
	property p_dir_cause;
		s_kp_steady ##0 $changed(pin_cfg.dir) |-> !sda_oe_n || !$past(sda_oe_n);
	endproperty
	a_dir_cause: assert property (p_dir_cause)
		else $error("direction changed without a write");
endmodule

bind gpcfg_top gpcfg_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .keypad_sel(keypad_sel), .pin_cfg(pin_cfg));

/* verif/test_gpio_pin_config_bank.sv */
// Testbench for the configuration bank
`timescale 1ns/1ps
module test_gpio_pin_config_bank import gpcfg_pkg::*;;
	logic sys_clk, rst, scl, sda_h, sda_line, strap, sda_out, sda_oe_n, ok;
	logic [NUM_PINS-1:0] kp, ed, el, eb, ep;
	gpcfg_pins_s pin_cfg;
	logic [7:0] cfg[13], got[13];
	int fails = 0;
	int comparisons = 0;
	// Open-drain line, pulled up when nobody pulls low
	assign sda_line = sda_h & (sda_oe_n | sda_out);
	gpcfg_top dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_alt_strap(strap),
		.keypad_sel(kp), .pin_cfg(pin_cfg));
	gpcfg_host host (.sys_clk(sys_clk), .sda(sda_line), .scl(scl), .sda_h(sda_h));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [NUM_PINS-1:0] g, e, input string m);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic do_reset(input logic s);
		rst = 1'b1;
		strap = s;
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask
	task automatic t_reset();
		chk(pin_cfg.dir, 18'h0, "dir reset");
		chk(pin_cfg.irq_level, 18'h0, "level reset");
		chk(pin_cfg.filter_bypass, 18'h0, "bypass reset");
		chk(pin_cfg.pullup_en, 18'h3ffff, "pull reset");
	endtask
	task automatic t_bank();
		cfg = '{8'h0f, 8'h33, 8'hfd, 8'ha5, 8'h5a, 8'hfe, 8'h3c, 8'hc3, 8'hff, 8'hff,
			8'h0f, 8'hfe, 8'h77};
		host.wr(ADDR_WR_STD, OFF_DIR_ROWS, cfg, 13, ok);
		chk(18'(ok), 18'h1, "burst write");
		repeat (2) @(negedge sys_clk);
		ed = {cfg[2][1:0], cfg[1], cfg[0]};
		el = {cfg[5][1:0], cfg[4], cfg[3]};
		eb = {cfg[8][1:0], cfg[7], cfg[6]};
		ep = {cfg[11][1:0], cfg[10], cfg[9]};
		chk(pin_cfg.dir, ed, "dir");
		chk(pin_cfg.irq_level, el, "level");
		chk(pin_cfg.filter_bypass, eb, "bypass");
		chk(pin_cfg.pullup_en, ~ed & ~ep, "pull");
		host.rd(ADDR_WR_STD, OFF_DIR_ROWS, 13, got, ok);
		chk(18'(ok), 18'h1, "burst read");
		for (int i = 0; i < 13; i++)
			chk(18'(got[i]), 18'(i == 12 ? 8'h00 : i % 3 == 2 ? cfg[i] & HIGH_BYTE_MASK :
				cfg[i]), "readback");
	endtask
	task automatic t_keypad();
		kp = 18'h2f0f0;
		repeat (3) @(negedge sys_clk);
		chk(pin_cfg.dir, ed & ~kp, "keypad dir");
		chk(pin_cfg.irq_level, el & ~kp, "keypad level");
		chk(pin_cfg.filter_bypass, eb & ~kp, "keypad bypass");
		chk(pin_cfg.pullup_en, ~(ed & ~kp) & ~(ep & ~kp), "keypad pull");
		kp = 18'h0;
	endtask
	task automatic t_addr();
		host.wr(8'h62, OFF_DIR_ROWS, cfg, 1, ok);
		chk(18'(ok), 18'h0, "foreign address");
		do_reset(1'b1);
		chk(pin_cfg.dir, 18'h0, "dir cleared");
		host.wr(ADDR_WR_STD, OFF_DIR_ROWS, cfg, 1, ok);
		chk(18'(ok), 18'h0, "standard on alternate");
		host.wr(ADDR_WR_ALT, OFF_DIR_ROWS, cfg, 1, ok);
		chk(18'(ok), 18'h1, "alternate address");
		repeat (2) @(negedge sys_clk);
		chk(pin_cfg.dir, {10'h0, cfg[0]}, "alternate write");
		host.rd(ADDR_WR_ALT, OFF_DIR_ROWS, 1, got, ok);
		chk(18'(ok), 18'h1, "alternate read");
		chk(18'(got[0]), 18'(cfg[0]), "alternate readback");
	endtask
	task automatic print_verdict();
		$display("Mismatches %0d, comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Run needs about 8400 cycles
	initial begin
		repeat (40000) @(posedge sys_clk);
		fails++;
		print_verdict();
	end
	initial begin
		kp = 18'h0;
		do_reset(1'b0);
		t_reset();
		t_bank();
		t_keypad();
		t_addr();
		print_verdict();
	end
endmodule
